//--- logic/cawpwm_top.sv
// Purpose: Shared 16-bit counter array with wide PWM channels over APB
// Assumes: 25 MHz clk, synchronous active-low nrst, external inputs asynchronous
// Notes: Only wide PWM behaviour of the channels is built
// Operation
// - Wide PWM runs independently of the shared shorter cycle-length setting.
// - Wide PWM when compare enable, PWM select and wide select all set.
// - Output goes high when counter equals the channel compare value.
// - Output goes low when the counter overflows.
// - Duty is (65536 minus compare)/65536; zero gives full high.
// - Compare enable cleared holds output low.
// - Match with match flag enable sets the channel event flag.
// - Low byte write clears compare enable; high byte write sets it.
// - Wrap flag set on 0xffff to 0x0000; only software clears it.
// - Wrap interrupt enable gates the wrap flag onto the interrupt.
// - Counter counts only while the run bit is one.
// - Channel event flags request interrupt when enabled; software clears.
// - Idle suspend stops the counter array while the processor idles.
// - Timebase select picks sysclk/12, /4, timer0, ext falls, sysclk, ext/8.
// - Unused control and mode bits read zero, ignore writes.
// - Shared cycle-length selection is ignored for wide PWM channels.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module cawpwm_top #(
  parameter int NCH = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuIdle,
  input wire logic timer0Ovf,
  input wire logic externalCountInput,
  input wire logic externalClockIn,
  output logic [NCH-1:0] moduleOutputPin,
  output logic irq
);
  // Only three event flag bits exist in the control register
  if (NCH < 1 || NCH > 3)
  begin : g_nchCheck
    $error("NCH must be 1 to 3");
  end

  logic [7:0] controlReg;
  logic [7:0] modeReg;
  logic [1:0] cycleLengthReg;
  logic [15:0] counterReg;
  logic [7:0] chModeReg [NCH];
  logic [15:0] cmpReg [NCH];
  logic [NCH-1:0] matchHit;
  logic [2:0] eciSync;
  logic [2:0] extSync;
  logic [1:0] idleSync;
  logic [1:0] t0Sync;
  logic t0Prev;
  logic [3:0] divReg;
  logic [2:0] ext8Reg;
  logic tick;
  logic countEn;
  logic wrapEvt;
  logic wrEn;
  logic chIrq;

  assign wrEn = psel & penable & pwrite;

  // Synchronisers for outside inputs
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      eciSync <= 3'h7;
      extSync <= 3'h0;
      idleSync <= 2'h0;
      t0Sync <= 2'h0;
      t0Prev <= 1'b0;
    end
    else
    begin
      eciSync <= {eciSync[1:0], externalCountInput};
      extSync <= {extSync[1:0], externalClockIn};
      idleSync <= {idleSync[0], cpuIdle};
      t0Sync <= {t0Sync[0], timer0Ovf};
      t0Prev <= t0Sync[1];
    end
  end

  // System clock dividers and external clock divider
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      divReg <= 4'h0;
      ext8Reg <= 3'h0;
    end
    else
    begin
      if ((modeReg[3:1] == cawpwm_pkg::TB_DIV12 && divReg == cawpwm_pkg::DIV12_LAST) ||
          (modeReg[3:1] == cawpwm_pkg::TB_DIV4 && divReg == cawpwm_pkg::DIV4_LAST))
        divReg <= 4'h0;
      else
        divReg <= divReg + 4'h1;
      if (extSync[1] & ~extSync[2])
        ext8Reg <= ext8Reg + 3'h1;
    end
  end

  // Timebase selection
  always_comb
  begin
    case (modeReg[3:1])
      cawpwm_pkg::TB_DIV12: tick = (divReg == cawpwm_pkg::DIV12_LAST);
      cawpwm_pkg::TB_DIV4: tick = (divReg == cawpwm_pkg::DIV4_LAST);
      cawpwm_pkg::TB_TMR0: tick = t0Sync[1] & ~t0Prev;
      cawpwm_pkg::TB_EXTFALL: tick = eciSync[2] & ~eciSync[1];
      cawpwm_pkg::TB_SYSCLK: tick = 1'b1;
      cawpwm_pkg::TB_EXTDIV8: tick = extSync[1] & ~extSync[2] &
                                     (ext8Reg == cawpwm_pkg::EXT8_LAST);
      default: tick = 1'b0;
    endcase
  end

  // Run and idle gating
  assign countEn = tick & controlReg[cawpwm_pkg::CTL_RUN] &
                   ~(modeReg[cawpwm_pkg::MD_IDLE] & idleSync[1]);
  assign wrapEvt = countEn && counterReg == cawpwm_pkg::CNT_TOP;

  // Shared counter
  always_ff @(posedge clk)
  begin
    if (!nrst)
      counterReg <= cawpwm_pkg::RST_WORD;
    else if (wrEn && paddr == cawpwm_pkg::OFF_COUNTER)
      counterReg <= pwdata[15:0];
    else if (countEn)
      counterReg <= counterReg + 16'h0001;
  end

  // Control register: run bit, sticky flags with set winning
  always_ff @(posedge clk)
  begin
    if (!nrst)
      controlReg <= cawpwm_pkg::RST_BYTE;
    else
    begin
      if (wrEn && paddr == cawpwm_pkg::OFF_CONTROL)
      begin
        controlReg[cawpwm_pkg::CTL_RUN] <= pwdata[cawpwm_pkg::CTL_RUN];
        controlReg[cawpwm_pkg::CTL_WRAP] <= pwdata[cawpwm_pkg::CTL_WRAP] | wrapEvt;
        controlReg[NCH-1:0] <= pwdata[NCH-1:0] | matchHit;
      end
      else
      begin
        controlReg[cawpwm_pkg::CTL_WRAP] <= controlReg[cawpwm_pkg::CTL_WRAP] | wrapEvt;
        controlReg[NCH-1:0] <= controlReg[NCH-1:0] | matchHit;
      end
    end
  end

  // Mode and cycle-length registers; unused bits stay zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      modeReg <= cawpwm_pkg::RST_BYTE;
      cycleLengthReg <= 2'h0;
    end
    else
    begin
      if (wrEn && paddr == cawpwm_pkg::OFF_MODE)
        modeReg <= {pwdata[7], 3'h0, pwdata[3:0]};
      if (wrEn && paddr == cawpwm_pkg::OFF_CYCLEN)
        cycleLengthReg <= pwdata[1:0];
    end
  end

  // Per-channel compare, mode and output
  for (genvar n = 0; n < NCH; n++)
  begin : g_ch
    localparam logic [11:0] OFFS = 12'(n) * cawpwm_pkg::CH_STRIDE;
    logic wideMode;
    assign wideMode = chModeReg[n][cawpwm_pkg::CM_CMPEN] & chModeReg[n][cawpwm_pkg::CM_PWM] &
                      chModeReg[n][cawpwm_pkg::CM_WIDE];
    assign matchHit[n] = chModeReg[n][cawpwm_pkg::CM_CMPEN] &
                         chModeReg[n][cawpwm_pkg::CM_MATCH] &
                         countEn && (counterReg + 16'h0001) == cmpReg[n];

    // Mode and compare bytes
    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        chModeReg[n] <= cawpwm_pkg::RST_BYTE;
        cmpReg[n] <= cawpwm_pkg::RST_WORD;
      end
      else if (wrEn && paddr == cawpwm_pkg::OFF_CMODE0 + OFFS)
        chModeReg[n] <= pwdata[7:0];
      else if (wrEn && paddr == cawpwm_pkg::OFF_CMPL0 + OFFS)
      begin
        cmpReg[n][7:0] <= pwdata[7:0];
        chModeReg[n][cawpwm_pkg::CM_CMPEN] <= 1'b0;
      end
      else if (wrEn && paddr == cawpwm_pkg::OFF_CMPH0 + OFFS)
      begin
        cmpReg[n][15:8] <= pwdata[7:0];
        chModeReg[n][cawpwm_pkg::CM_CMPEN] <= 1'b1;
      end
    end

    // Output: set on match, clear on overflow, ignores cycle length
    always_ff @(posedge clk)
    begin
      if (!nrst)
        moduleOutputPin[n] <= 1'b0;
      else if (!chModeReg[n][cawpwm_pkg::CM_CMPEN])
        moduleOutputPin[n] <= 1'b0;
      else if (wideMode && countEn)
      begin
        if ((counterReg + 16'h0001) == cmpReg[n])
          moduleOutputPin[n] <= 1'b1;
        else if (wrapEvt)
          moduleOutputPin[n] <= 1'b0;
      end
    end

    // Output, event flag, compare enable and interrupt checks
    property p_rise;
      @(posedge clk) disable iff (!nrst)
      $rose(moduleOutputPin[n]) |-> counterReg == cmpReg[n];
    endproperty
    a_rise: assert property (p_rise) else $error("output rose off match");
    property p_low;
      @(posedge clk) disable iff (!nrst)
      !chModeReg[n][cawpwm_pkg::CM_CMPEN] |=> !moduleOutputPin[n];
    endproperty
    a_low: assert property (p_low) else $error("output high while disabled");
    property p_fall;
      @(posedge clk) disable iff (!nrst)
      (wideMode && wrapEvt && cmpReg[n] != 16'h0000) |=> !moduleOutputPin[n];
    endproperty
    a_fall: assert property (p_fall) else $error("output not low on overflow");
    property p_flag;
      @(posedge clk) disable iff (!nrst)
      matchHit[n] |=> controlReg[n];
    endproperty
    a_flag: assert property (p_flag) else $error("event flag not set");
    property p_lowwr;
      @(posedge clk) disable iff (!nrst)
      (wrEn && paddr == cawpwm_pkg::OFF_CMPL0 + OFFS) |=>
        !chModeReg[n][cawpwm_pkg::CM_CMPEN];
    endproperty
    a_lowwr: assert property (p_lowwr) else $error("low byte kept enable");
    property p_hiwr;
      @(posedge clk) disable iff (!nrst)
      (wrEn && paddr == cawpwm_pkg::OFF_CMPH0 + OFFS) |=>
        chModeReg[n][cawpwm_pkg::CM_CMPEN];
    endproperty
    a_hiwr: assert property (p_hiwr) else $error("high byte left enable clear");
    property p_chirq;
      @(posedge clk) disable iff (!nrst)
      (controlReg[n] && chModeReg[n][cawpwm_pkg::CM_IRQEN]) |=> irq;
    endproperty
    a_chirq: assert property (p_chirq) else $error("event irq missing");
    c_pulse: cover property (@(posedge clk) disable iff (!nrst)
      $rose(moduleOutputPin[n]) ##[1:300] $fell(moduleOutputPin[n]));
  end

  // Channel requests from enabled event flags
  always_comb
  begin
    chIrq = 1'b0;
    for (int k = 0; k < NCH; k++)
      chIrq = chIrq | (controlReg[k] & chModeReg[k][cawpwm_pkg::CM_IRQEN]);
  end

  // Interrupt level from unmasked flags
  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= chIrq | (controlReg[cawpwm_pkg::CTL_WRAP] &
                      modeReg[cawpwm_pkg::MD_WRAPIE]);
  end

  // APB read data and ready
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (paddr == cawpwm_pkg::OFF_CONTROL)
          prdata[7:0] <= {controlReg[7:6], 3'h0, controlReg[2:0]};
        else if (paddr == cawpwm_pkg::OFF_MODE)
          prdata[7:0] <= modeReg;
        else if (paddr == cawpwm_pkg::OFF_COUNTER)
          prdata[15:0] <= counterReg;
        else if (paddr == cawpwm_pkg::OFF_CYCLEN)
          prdata[1:0] <= cycleLengthReg;
        else if (paddr == cawpwm_pkg::OFF_IDLE)
          prdata[0] <= idleSync[1];
        for (int k = 0; k < NCH; k++)
        begin
          if (paddr == cawpwm_pkg::OFF_CMODE0 + 12'(k * 4))
            prdata[7:0] <= chModeReg[k];
          if (paddr == cawpwm_pkg::OFF_CMPL0 + 12'(k * 4))
            prdata[7:0] <= cmpReg[k][7:0];
          if (paddr == cawpwm_pkg::OFF_CMPH0 + 12'(k * 4))
            prdata[7:0] <= cmpReg[k][15:8];
        end
      end
    end
  end

  // Counter and flag checks
  property p_run;
    @(posedge clk) disable iff (!nrst)
    (!controlReg[cawpwm_pkg::CTL_RUN] && !(wrEn && paddr == cawpwm_pkg::OFF_COUNTER))
      |=> $stable(counterReg);
  endproperty
  a_run: assert property (p_run) else $error("counter moved while stopped");
  property p_wrap;
    @(posedge clk) disable iff (!nrst)
    wrapEvt |=> controlReg[cawpwm_pkg::CTL_WRAP] && counterReg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");
  property p_irq;
    @(posedge clk) disable iff (!nrst)
    (controlReg[cawpwm_pkg::CTL_WRAP] && modeReg[cawpwm_pkg::MD_WRAPIE]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("wrap irq missing");
  property p_unused;
    @(posedge clk) disable iff (!nrst)
    modeReg[6:4] == 3'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused mode bits set");
  property p_unusedCtl;
    @(posedge clk) disable iff (!nrst)
    controlReg[5:3] == 3'h0;
  endproperty
  a_unusedCtl: assert property (p_unusedCtl) else $error("unused control bits set");
  property p_idle;
    @(posedge clk) disable iff (!nrst)
    (modeReg[cawpwm_pkg::MD_IDLE] && idleSync[1] &&
      !(wrEn && paddr == cawpwm_pkg::OFF_COUNTER)) |=> $stable(counterReg);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved while suspended");
  // Full-rate timebase steps the shared counter once per clock
  property p_step;
    @(posedge clk) disable iff (!nrst)
    (controlReg[cawpwm_pkg::CTL_RUN] && modeReg[3:1] == cawpwm_pkg::TB_SYSCLK &&
      !(modeReg[cawpwm_pkg::MD_IDLE] && idleSync[1]) &&
      !(wrEn && paddr == cawpwm_pkg::OFF_COUNTER)) |=>
      counterReg == $past(counterReg) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("counter missed a tick");
  c_wrap: cover property (@(posedge clk) disable iff (!nrst) wrapEvt);
  c_irq: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
  c_tb: cover property (@(posedge clk) disable iff (!nrst)
    modeReg[3:1] == cawpwm_pkg::TB_DIV12 && countEn);
endmodule : cawpwm_top

//--- logic/cawpwm_pkg.sv
// Purpose: Constants for the counter array wide PWM block
// Assumes: APB with 32-bit data, one register per word; mode sits at unaligned 0x0ed
// Notes: Offsets that the map gives directly are byte addresses
package cawpwm_pkg;
  // Printed offsets, used as byte addresses
  localparam logic [11:0] OFF_CONTROL = 12'h0d8;
  localparam logic [11:0] OFF_MODE = 12'h0ed;
  // Registers of our own
  localparam logic [11:0] OFF_CMODE0 = 12'h100;
  localparam logic [11:0] OFF_CMPL0 = 12'h110;
  localparam logic [11:0] OFF_CMPH0 = 12'h120;
  localparam logic [11:0] OFF_COUNTER = 12'h130;
  localparam logic [11:0] OFF_IDLE = 12'h134;
  localparam logic [11:0] OFF_CYCLEN = 12'h138;
  localparam logic [11:0] CH_STRIDE = 12'h004;
  // Control register fields
  localparam int CTL_WRAP = 7;
  localparam int CTL_RUN = 6;
  // Mode register fields
  localparam int MD_IDLE = 7;
  localparam int MD_TB_LSB = 1;
  localparam int MD_WRAPIE = 0;
  // Per-channel mode fields
  localparam int CM_WIDE = 7;
  localparam int CM_CMPEN = 6;
  localparam int CM_MATCH = 3;
  localparam int CM_PWM = 1;
  localparam int CM_IRQEN = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Timebase codes
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_TMR0 = 3'h2;
  localparam logic [2:0] TB_EXTFALL = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_EXTDIV8 = 3'h5;
  // Divider counts
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [2:0] EXT8_LAST = 3'h7;
  localparam logic [15:0] CNT_TOP = 16'hffff;
endpackage : cawpwm_pkg

//--- bench/cawpwm_load.sv
// Purpose: External load on one wide PWM output pin
// Assumes: Pin is a registered level in the clk domain
// Notes: Reports the length of the last completed high pulse
`timescale 1ns/1ps
module cawpwm_load (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic [31:0] lastHigh
);
  logic [31:0] highRun_reg;

  // Count high cycles, latch the total when the pin drops
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      highRun_reg <= 32'h0;
      lastHigh <= 32'h0;
    end
    else if (pin)
      highRun_reg <= highRun_reg + 32'h1;
    else if (highRun_reg != 32'h0)
    begin
      lastHigh <= highRun_reg;
      highRun_reg <= 32'h0;
    end
  end
endmodule : cawpwm_load

//--- bench/cawpwm_tb.sv
// Purpose: Self-checking bench for the wide PWM counter array
// Assumes: APB slave answers within a few cycles
// Notes: Timebase windows allow a small phase slack
`timescale 1ns/1ps
module cawpwm_tb;
  logic clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpuIdle;
  logic timer0Ovf;
  logic extCnt;
  logic extClk;
  logic [2:0] pin;
  logic irq;
  logic [31:0] lastHigh;
  logic [31:0] rdv;
  logic [31:0] held;
  int highs;
  int failCount = 0;
  int checked = 0;
  // Timebase cases: mode byte and accepted counter range
  logic [7:0] tbMode [0:8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h88, 8'h08};
  int lo [0:8] = '{4, 15, 6, 6, 64, 0, 0, 0, 64};
  int hi [0:8] = '{7, 18, 9, 9, 68, 2, 0, 0, 68};

  cawpwm_top cawpwm_top_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuIdle(cpuIdle), .timer0Ovf(timer0Ovf), .externalCountInput(extCnt),
    .externalClockIn(extClk), .moduleOutputPin(pin), .irq(irq));
  cawpwm_load cawpwm_load_inst (.clk(clk), .nrst(nrst), .pin(pin[0]), .lastHigh(lastHigh));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic printVerdict;
    $display("Comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : printVerdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chkRng(input string nm, input int l, input int h, input logic [31:0] got);
    checked++;
    if ($isunknown(got) || got < l || got > h)
    begin
      failCount++;
      $display("ERROR %s expected %0d..%0d seen %h", nm, l, h, got);
    end
  endtask : chkRng

  // One APB transfer; read data lands in rdv
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failCount++;
      printVerdict();
    end
    @(posedge clk);
  endtask : apb

  task automatic waitPin(input logic lvl);
    int n;
    n = 0;
    while (pin[0] !== lvl && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (pin[0] !== lvl)
    begin
      failCount++;
      printVerdict();
    end
  endtask : waitPin

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpuIdle = 1'b0;
    timer0Ovf = 1'b0;
    extCnt = 1'b0;
    extClk = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, cawpwm_pkg::OFF_CONTROL, 32'h0);
    chk("control", 32'h0, rdv);
    apb(1'b1, cawpwm_pkg::OFF_MODE, 32'h7f);
    apb(1'b0, cawpwm_pkg::OFF_MODE, 32'h0);
    chk("mode", 32'h0f, rdv);
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h38);
    apb(1'b0, cawpwm_pkg::OFF_CONTROL, 32'h0);
    chk("control", 32'h0, rdv);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 32'h0, rdv);
    // Each timebase and idle setting over a fixed run window
    for (int i = 0; i < 9; i++)
    begin
      cpuIdle <= (i > 6);
      apb(1'b1, cawpwm_pkg::OFF_MODE, {24'h0, tbMode[i]});
      apb(1'b1, cawpwm_pkg::OFF_COUNTER, 32'h0);
      apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h40);
      for (int j = 0; j < 64; j++)
      begin
        timer0Ovf <= j[2];
        extCnt <= j[2];
        extClk <= j[2];
        @(posedge clk);
      end
      apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h0);
      apb(1'b0, cawpwm_pkg::OFF_COUNTER, 32'h0);
      chkRng("counter", lo[i], hi[i], rdv);
    end
    cpuIdle <= 1'b0;
    // Wide PWM pulse, flags and interrupt
    apb(1'b1, cawpwm_pkg::OFF_CYCLEN, 32'h3);
    apb(1'b1, cawpwm_pkg::OFF_CMODE0, 32'h8b);
    apb(1'b1, cawpwm_pkg::OFF_CMPL0, 32'hf0);
    apb(1'b1, cawpwm_pkg::OFF_CMPH0, 32'hff);
    apb(1'b0, cawpwm_pkg::OFF_CMODE0, 32'h0);
    chk("chmode", 32'hcb, rdv);
    apb(1'b1, cawpwm_pkg::OFF_MODE, 32'h08);
    apb(1'b1, cawpwm_pkg::OFF_COUNTER, 32'hffe0);
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h40);
    waitPin(1'b1);
    waitPin(1'b0);
    @(posedge clk);
    chk("high time", 32'd16, lastHigh);
    apb(1'b0, cawpwm_pkg::OFF_CONTROL, 32'h0);
    chk("flags", 32'hc1, rdv);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h40);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Wrap flag gated by its enable
    apb(1'b1, cawpwm_pkg::OFF_CMODE0, 32'hca);
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h80);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, cawpwm_pkg::OFF_MODE, 32'h09);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h0);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Stopped counter keeps its value
    apb(1'b0, cawpwm_pkg::OFF_COUNTER, 32'h0);
    held = rdv;
    repeat (10) @(posedge clk);
    apb(1'b0, cawpwm_pkg::OFF_COUNTER, 32'h0);
    chk("halted", held, rdv);
    // Low byte write drops compare enable, output stays low
    apb(1'b1, cawpwm_pkg::OFF_CMPL0, 32'hf8);
    apb(1'b0, cawpwm_pkg::OFF_CMODE0, 32'h0);
    chk("chmode", 32'h8a, rdv);
    apb(1'b1, cawpwm_pkg::OFF_COUNTER, 32'hffe0);
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h40);
    highs = 0;
    repeat (60)
    begin
      @(posedge clk);
      highs += (pin[0] === 1'b1);
    end
    chk("high cycles", 32'h0, highs);
    apb(1'b1, cawpwm_pkg::OFF_CMPH0, 32'hff);
    apb(1'b0, cawpwm_pkg::OFF_CMODE0, 32'h0);
    chk("chmode", 32'hca, rdv);
    // Zero compare on channel 1 goes high at the wrap and stays high; channel 2 stays off
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h0);
    apb(1'b1, cawpwm_pkg::OFF_CMODE0 + cawpwm_pkg::CH_STRIDE, 32'h82);
    apb(1'b1, cawpwm_pkg::OFF_CMPL0 + cawpwm_pkg::CH_STRIDE, 32'h0);
    apb(1'b1, cawpwm_pkg::OFF_CMPH0 + cawpwm_pkg::CH_STRIDE, 32'h0);
    apb(1'b1, cawpwm_pkg::OFF_COUNTER, 32'hfff0);
    apb(1'b1, cawpwm_pkg::OFF_CONTROL, 32'h40);
    repeat (30) @(posedge clk);
    highs = 0;
    held = 32'h0;
    repeat (100)
    begin
      @(posedge clk);
      highs += (pin[1] === 1'b1);
      held += {31'h0, pin[2] === 1'b1};
    end
    chk("full duty", 32'd100, highs);
    chk("idle channel", 32'h0, held);
    printVerdict();
  end
endmodule : cawpwm_tb
